// *** logic/ccpc_pkg.sv ***
// Operation
// - The 16-bit compare value is checked against the 16-bit Timer1 count every cycle, and equality is a match.
// - A match performs the action chosen by the four-bit mode: toggle, set, clear, trigger or interrupt only.
// - Every compare mode sets the unit's interrupt flag on a match.
// - Mode 1010 only raises the interrupt flag and leaves the pin undriven.
// - Mode 1011 issues a special event trigger that resets Timer1 and leaves the pin undriven.
// - A special event trigger clears both Timer1 count bytes without setting the Timer1 overflow flag.
// - On the second unit only, the trigger sets the converter go flag when the converter is on.
// - The trigger asserts on the match, but the Timer1 reset waits for the next Timer1 clock edge.
// - If the match is gone by that Timer1 clock edge, the Timer1 reset is not done.
// - Writing zero to a control register forces that unit's compare output latch low.
// - The second compare output goes to one of two port pins, chosen by the pin select bit.
// - Compare depends on the system clock and does not work during sleep.
`default_nettype none
package ccpc_pkg;
   // APB byte offsets
   localparam logic [7:0] OFS_CTRL1   = 8'h00;
   localparam logic [7:0] OFS_CTRL2   = 8'h04;
   localparam logic [7:0] OFS_VAL1_LO = 8'h08;
   localparam logic [7:0] OFS_VAL1_HI = 8'h0c;
   localparam logic [7:0] OFS_VAL2_LO = 8'h10;
   localparam logic [7:0] OFS_VAL2_HI = 8'h14;
   localparam logic [7:0] OFS_ALTPIN  = 8'h18;
   localparam logic [7:0] OFS_TMR_LO  = 8'h1c;
   localparam logic [7:0] OFS_TMR_HI  = 8'h20;
   localparam logic [7:0] OFS_TMR_CTL = 8'h24;
   localparam logic [7:0] OFS_ADC     = 8'h28;
   localparam logic [7:0] OFS_IRQ_ST  = 8'h2c;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h30;
   localparam logic [7:0] OFS_IRQ_EN  = 8'h34;
   localparam logic [7:0] OFS_PINDIR  = 8'h38;
   // Compare modes
   localparam logic [3:0] MODE_OFF    = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_SET    = 4'h8;
   localparam logic [3:0] MODE_CLR    = 4'h9;
   localparam logic [3:0] MODE_SWIRQ  = 4'ha;
   localparam logic [3:0] MODE_TRIG   = 4'hb;
   // Field positions
   localparam int BIT_TMR_ON  = 0;
   localparam int BIT_TMR_EXT = 1;
   localparam int BIT_ADC_ON  = 0;
   localparam int BIT_ADC_GO  = 1;
   localparam int BIT_ALT_SEL = 0;
   localparam int IRQ_CMP1    = 0;
   localparam int IRQ_CMP2    = 1;
   localparam int IRQ_TOVF    = 2;
   localparam int NUM_IRQ     = 3;
   localparam int PIN_CMP1    = 0;
   localparam int PIN_PC1     = 1;
   localparam int PIN_PB3     = 2;
   // Reset values
   localparam logic [5:0] CTRL_RST   = 6'h00;
   localparam logic [2:0] PINDIR_RST = 3'h7;
   // Instruction clock is the system clock divided by four
   localparam int INSTR_DIV = 4;
endpackage
`default_nettype wire

// *** logic/ccpc_cmp_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccpc_cmp_unit (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Configuration
   input  wire logic [3:0]  mode,
   input  wire logic        ctrl_zero_wr,
   input  wire logic [15:0] cmp_value,
   // Timer side
   input  wire logic [15:0] count,
   input  wire logic        tmr_tick,
   input  wire logic        active,
   // Results
   output logic             match_evt,
   output logic             trig_evt,
   output logic             tmr_reset,
   output logic             out_latch,
   output logic             pin_ctrl
);
   logic match;
   logic prev_match_ff;
   logic pend_ff;
   logic out_ff;
   logic cmp_mode;

   assign match    = (cmp_value == count);
   // Codes above the trigger mode belong to PWM, not to compare
   assign cmp_mode = (mode[3:2] == 2'b10) || (mode == ccpc_pkg::MODE_TOGGLE);
   // Edge of the match, so a count that sits still acts once
   assign match_evt = active && cmp_mode && match && !prev_match_ff;
   assign trig_evt  = match_evt && (mode == ccpc_pkg::MODE_TRIG);
   // Recheck the match at the timer edge; a moved value cancels
   assign tmr_reset = pend_ff && tmr_tick && match;
   assign pin_ctrl  = (mode == ccpc_pkg::MODE_TOGGLE) || (mode == ccpc_pkg::MODE_SET) ||
                      (mode == ccpc_pkg::MODE_CLR);
   assign out_latch = out_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_match_ff <= 1'b0;
      end else if (active) begin
         prev_match_ff <= match;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ff <= 1'b0;
      end else if (trig_evt) begin
         pend_ff <= 1'b1;
      end else if (tmr_tick || (mode != ccpc_pkg::MODE_TRIG)) begin
         pend_ff <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ff <= 1'b0;
      end else if (ctrl_zero_wr) begin
         out_ff <= 1'b0;
      end else if (match_evt) begin
         case (mode)
            ccpc_pkg::MODE_TOGGLE: out_ff <= !out_ff;
            ccpc_pkg::MODE_SET:    out_ff <= 1'b1;
            ccpc_pkg::MODE_CLR:    out_ff <= 1'b0;
            default:               out_ff <= out_ff;
         endcase
      end
   end
endmodule // ccpc_cmp_unit
`default_nettype wire

// *** logic/ccpc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccpc_top #(
   parameter int NUM_UNITS = 2,
   parameter int CNT_W     = 16
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Timer and converter partners
   input  wire logic        t1_ext_clk,
   input  wire logic        sleep_mode,
   input  wire logic        adc_done,
   output logic             adc_go,
   output logic [1:0]       special_event,
   // Pins
   output logic             cmp1_pin,
   output logic             cmp1_pin_oe,
   output logic             port_c_pin1,
   output logic             port_c_pin1_oe,
   output logic             port_b_pin3,
   output logic             port_b_pin3_oe
);
   // Register state
   logic [5:0]                 ctrl_ff      [NUM_UNITS];
   logic [CNT_W-1:0]           cval_ff      [NUM_UNITS];
   logic                       alt_sel_ff;
   logic [1:0]                 tmr_ctl_ff;
   logic                       adc_on_ff;
   logic                       adc_go_ff;
   logic [ccpc_pkg::NUM_IRQ-1:0] irq_st_ff;
   logic [ccpc_pkg::NUM_IRQ-1:0] irq_en_ff;
   logic [2:0]                 pindir_ff;
   logic [CNT_W-1:0]           count_ff;
   // Timer clocking
   logic [1:0]                 div_ff;
   logic                       ext_s1_ff;
   logic                       ext_s2_ff;
   logic                       ext_prev_ff;
   logic                       tmr_tick;
   logic                       active;
   // Bus decode
   logic                       wr_en;
   logic                       setup;
   logic [3:0]                 wr_idx;
   // Unit results
   logic [NUM_UNITS-1:0]       match_evt;
   logic [NUM_UNITS-1:0]       trig_evt;
   logic [NUM_UNITS-1:0]       tmr_reset;
   logic [NUM_UNITS-1:0]       out_latch;
   logic [NUM_UNITS-1:0]       pin_ctrl;
   logic [NUM_UNITS-1:0]       ctrl_zero_wr;
   logic                       tmr_clear;
   logic                       tmr_ovf;
   logic [ccpc_pkg::NUM_IRQ-1:0] irq_set;
   // Output flops
   logic [31:0]                prdata_ff;
   logic                       pready_ff;
   logic                       pslverr_ff;
   logic                       irq_ff;
   logic [1:0]                 sev_ff;
   logic                       cmp1_o_ff;
   logic                       cmp1_oe_ff;
   logic                       pc1_o_ff;
   logic                       pc1_oe_ff;
   logic                       pb3_o_ff;
   logic                       pb3_oe_ff;
   logic [31:0]                nxt_prdata;

   // Maps an address to a register index, 0 when unmapped
   function automatic logic [3:0] reg_index(input logic [7:0] a);
      if (a == ccpc_pkg::OFS_CTRL1) begin
         return 4'h1;
      end else if (a == ccpc_pkg::OFS_CTRL2) begin
         return 4'h2;
      end else if (a == ccpc_pkg::OFS_VAL1_LO) begin
         return 4'h3;
      end else if (a == ccpc_pkg::OFS_VAL1_HI) begin
         return 4'h4;
      end else if (a == ccpc_pkg::OFS_VAL2_LO) begin
         return 4'h5;
      end else if (a == ccpc_pkg::OFS_VAL2_HI) begin
         return 4'h6;
      end else if (a == ccpc_pkg::OFS_ALTPIN) begin
         return 4'h7;
      end else if (a == ccpc_pkg::OFS_TMR_LO) begin
         return 4'h8;
      end else if (a == ccpc_pkg::OFS_TMR_HI) begin
         return 4'h9;
      end else if (a == ccpc_pkg::OFS_TMR_CTL) begin
         return 4'ha;
      end else if (a == ccpc_pkg::OFS_ADC) begin
         return 4'hb;
      end else if (a == ccpc_pkg::OFS_IRQ_ST) begin
         return 4'hc;
      end else if (a == ccpc_pkg::OFS_IRQ_CLR) begin
         return 4'hd;
      end else if (a == ccpc_pkg::OFS_IRQ_EN) begin
         return 4'he;
      end else if (a == ccpc_pkg::OFS_PINDIR) begin
         return 4'hf;
      end else begin
         return 4'h0;
      end
   endfunction

   assign setup  = psel && !penable;
   assign wr_en  = psel && penable && pwrite;
   assign wr_idx = reg_index(paddr);

   // Timer1 clocking: instruction clock or a synchronised external pin
   assign active = !sleep_mode;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_ff <= 2'h0;
      end else begin
         div_ff <= div_ff + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_s1_ff   <= 1'b0;
         ext_s2_ff   <= 1'b0;
         ext_prev_ff <= 1'b0;
      end else begin
         ext_s1_ff   <= t1_ext_clk;
         ext_s2_ff   <= ext_s1_ff;
         ext_prev_ff <= ext_s2_ff;
      end
   end

   // Never the raw system clock; the compare needs idle cycles between counts
   assign tmr_tick = active && tmr_ctl_ff[ccpc_pkg::BIT_TMR_ON] &&
                     (tmr_ctl_ff[ccpc_pkg::BIT_TMR_EXT] ? (ext_s2_ff && !ext_prev_ff) :
                      (div_ff == 2'(ccpc_pkg::INSTR_DIV - 1)));

   // Compare units
   genvar gi;
   generate
      for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
         assign ctrl_zero_wr[gi] = wr_en && (wr_idx == 4'(1 + gi)) && (pwdata[5:0] == ccpc_pkg::CTRL_RST);
         ccpc_cmp_unit u_cmp (
            .pclk         (pclk),
            .presetn      (presetn),
            .mode         (ctrl_ff[gi][3:0]),
            .ctrl_zero_wr (ctrl_zero_wr[gi]),
            .cmp_value    (cval_ff[gi]),
            .count        (count_ff),
            .tmr_tick     (tmr_tick),
            .active       (active),
            .match_evt    (match_evt[gi]),
            .trig_evt     (trig_evt[gi]),
            .tmr_reset    (tmr_reset[gi]),
            .out_latch    (out_latch[gi]),
            .pin_ctrl     (pin_ctrl[gi])
         );

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ctrl_ff[gi] <= ccpc_pkg::CTRL_RST;
            end else if (wr_en && (wr_idx == 4'(1 + gi))) begin
               ctrl_ff[gi] <= pwdata[5:0];
            end
         end

         // Compare value has no defined reset; zero is used
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cval_ff[gi] <= '0;
            end else if (wr_en && (wr_idx == 4'(3 + 2 * gi))) begin
               cval_ff[gi][7:0] <= pwdata[7:0];
            end else if (wr_en && (wr_idx == 4'(4 + 2 * gi))) begin
               cval_ff[gi][15:8] <= pwdata[7:0];
            end
         end
      end
   endgenerate

   // Timer1 count; a write from software wins over the trigger reset
   assign tmr_clear = |tmr_reset;
   assign tmr_ovf   = tmr_tick && !tmr_clear && (count_ff == {CNT_W{1'b1}});
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_ff <= '0;
      end else if (wr_en && (wr_idx == 4'h8)) begin
         count_ff[7:0] <= pwdata[7:0];
      end else if (wr_en && (wr_idx == 4'h9)) begin
         count_ff[15:8] <= pwdata[7:0];
      end else if (tmr_clear) begin
         count_ff <= '0;
      end else if (tmr_tick) begin
         count_ff <= count_ff + 16'h0001;
      end
   end

   // Control registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alt_sel_ff <= 1'b0;
         tmr_ctl_ff <= 2'h0;
         adc_on_ff  <= 1'b0;
         irq_en_ff  <= '0;
         pindir_ff  <= ccpc_pkg::PINDIR_RST;
      end else if (wr_en) begin
         if (wr_idx == 4'h7) begin
            alt_sel_ff <= pwdata[ccpc_pkg::BIT_ALT_SEL];
         end else if (wr_idx == 4'ha) begin
            tmr_ctl_ff <= pwdata[1:0];
         end else if (wr_idx == 4'hb) begin
            adc_on_ff <= pwdata[ccpc_pkg::BIT_ADC_ON];
         end else if (wr_idx == 4'he) begin
            irq_en_ff <= pwdata[ccpc_pkg::NUM_IRQ-1:0];
         end else if (wr_idx == 4'hf) begin
            pindir_ff <= pwdata[2:0];
         end
      end
   end

   // Converter go flag; a trigger wins over completion or a software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_go_ff <= 1'b0;
      end else if (trig_evt[1] && adc_on_ff) begin
         adc_go_ff <= 1'b1;
      end else if (wr_en && (wr_idx == 4'hb)) begin
         adc_go_ff <= pwdata[ccpc_pkg::BIT_ADC_GO] && pwdata[ccpc_pkg::BIT_ADC_ON];
      end else if (adc_done || !adc_on_ff) begin
         adc_go_ff <= 1'b0;
      end
   end

   // Sticky status, set wins over clear; trigger reset never counts as overflow
   assign irq_set[ccpc_pkg::IRQ_CMP1] = match_evt[0];
   assign irq_set[ccpc_pkg::IRQ_CMP2] = match_evt[1];
   assign irq_set[ccpc_pkg::IRQ_TOVF] = tmr_ovf;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_st_ff <= '0;
      end else if (wr_en && (wr_idx == 4'hd)) begin
         irq_st_ff <= (irq_st_ff & ~pwdata[ccpc_pkg::NUM_IRQ-1:0]) | irq_set;
      end else begin
         irq_st_ff <= irq_st_ff | irq_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
         sev_ff <= 2'h0;
      end else begin
         irq_ff <= |(irq_st_ff & irq_en_ff);
         sev_ff <= trig_evt;
      end
   end

   // Pins: the unit drives only in output modes and with direction cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp1_o_ff  <= 1'b0;
         cmp1_oe_ff <= 1'b0;
         pc1_o_ff   <= 1'b0;
         pc1_oe_ff  <= 1'b0;
         pb3_o_ff   <= 1'b0;
         pb3_oe_ff  <= 1'b0;
      end else begin
         cmp1_o_ff  <= out_latch[0];
         cmp1_oe_ff <= pin_ctrl[0] && !pindir_ff[ccpc_pkg::PIN_CMP1];
         pc1_o_ff   <= out_latch[1];
         pc1_oe_ff  <= pin_ctrl[1] && !alt_sel_ff && !pindir_ff[ccpc_pkg::PIN_PC1];
         pb3_o_ff   <= out_latch[1];
         pb3_oe_ff  <= pin_ctrl[1] && alt_sel_ff && !pindir_ff[ccpc_pkg::PIN_PB3];
      end
   end

   // Read mux
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      case (wr_idx)
         4'h1: nxt_prdata[5:0] = ctrl_ff[0];
         4'h2: nxt_prdata[5:0] = ctrl_ff[1];
         4'h3: nxt_prdata[7:0] = cval_ff[0][7:0];
         4'h4: nxt_prdata[7:0] = cval_ff[0][15:8];
         4'h5: nxt_prdata[7:0] = cval_ff[1][7:0];
         4'h6: nxt_prdata[7:0] = cval_ff[1][15:8];
         4'h7: nxt_prdata[0] = alt_sel_ff;
         4'h8: nxt_prdata[7:0] = count_ff[7:0];
         4'h9: nxt_prdata[7:0] = count_ff[15:8];
         4'ha: nxt_prdata[1:0] = tmr_ctl_ff;
         4'hb: nxt_prdata[1:0] = {adc_go_ff, adc_on_ff};
         4'hc: nxt_prdata[ccpc_pkg::NUM_IRQ-1:0] = irq_st_ff;
         4'he: nxt_prdata[ccpc_pkg::NUM_IRQ-1:0] = irq_en_ff;
         4'hf: nxt_prdata[2:0] = pindir_ff;
         default: nxt_prdata = 32'h0000_0000;
      endcase
   end

   // Data is captured in setup so the access phase completes at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
         pready_ff  <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (setup) begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= (wr_idx == 4'h0);
         end
      end
   end

   assign prdata         = prdata_ff;
   assign pready         = pready_ff;
   assign pslverr        = pslverr_ff;
   assign irq            = irq_ff;
   assign adc_go         = adc_go_ff;
   assign special_event  = sev_ff;
   assign cmp1_pin       = cmp1_o_ff;
   assign cmp1_pin_oe    = cmp1_oe_ff;
   assign port_c_pin1    = pc1_o_ff;
   assign port_c_pin1_oe = pc1_oe_ff;
   assign port_b_pin3    = pb3_o_ff;
   assign port_b_pin3_oe = pb3_oe_ff;
endmodule // ccpc_top
`default_nettype wire

// *** tb/ccpc_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccpc_assertions (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Events and pins
   input wire logic        irq,
   input wire logic        adc_done,
   input wire logic        adc_go,
   input wire logic [1:0]  special_event,
   input wire logic        port_c_pin1_oe,
   input wire logic        port_b_pin3_oe
);
   logic adc_wr_ff;
   // Software start of a conversion, one cycle late to line up with go
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_wr_ff <= 1'b0;
      end else begin
         adc_wr_ff <= psel && penable && pwrite && paddr == ccpc_pkg::OFS_ADC;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence acc_s;
      psel && penable;
   endsequence
   sequence wr_s(logic [7:0] a);
      psel && penable && pwrite && paddr == a;
   endsequence
   apb_ready_a: assert property (acc_s |-> pready)
      else $error("access phase without ready");
   unmapped_err_a: assert property (acc_s ##0 paddr > 8'h38 |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (acc_s ##0 (paddr <= 8'h38 && paddr[1:0] == 2'b00) |-> !pslverr)
      else $error("mapped access refused");
   clr_reads_zero_a: assert property (acc_s ##0 (!pwrite && paddr == ccpc_pkg::OFS_IRQ_CLR) |-> prdata == 32'h0)
      else $error("clear register read not zero");
   irq_mask_a: assert property (wr_s(ccpc_pkg::OFS_IRQ_EN) ##0 pwdata[2:0] == 3'h0 |-> ##2 !irq)
      else $error("irq high with all enables off");
   event_once_a: assert property (special_event[0] |=> !special_event[0])
      else $error("unit one trigger longer than one cycle");
   trig_once_a: assert property ($rose(special_event[1]) |=> !special_event[1])
      else $error("unit two trigger longer than one cycle");
   alt_excl_a: assert property (!(port_c_pin1_oe && port_b_pin3_oe))
      else $error("both alternate pins driven");
   go_clear_a: assert property (adc_done |=> !adc_go || special_event[1])
      else $error("go flag survives conversion done");
   go_cause_a: assert property ($rose(adc_go) |-> special_event[1] || adc_wr_ff)
      else $error("go flag rose without trigger or write");
endmodule // ccpc_assertions
bind ccpc_top ccpc_assertions u_ccpc_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq), .adc_done(adc_done), .adc_go(adc_go),
   .special_event(special_event), .port_c_pin1_oe(port_c_pin1_oe), .port_b_pin3_oe(port_b_pin3_oe));
`default_nettype wire

// *** tb/ccpc_partner.sv ***
`timescale 1ns/100ps
`default_nettype none
module ccpc_partner #(
   parameter int CONV_CYC = 6,
   parameter int EXT_HIGH = 6
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Converter
   input  wire logic adc_go,
   output logic      adc_done,
   // Timer1 external clock
   input  wire logic ext_step,
   output logic      t1_ext_clk
);
   logic [3:0] conv_ff;
   logic [3:0] ext_ff;
   logic       done_ff;
   assign adc_done = done_ff;
   // External source, idle low, one slow pulse per step
   assign t1_ext_clk = (ext_ff != 4'h0);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_ff <= 4'h0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= adc_go && !done_ff && conv_ff == 4'(CONV_CYC - 1);
         conv_ff <= (adc_go && !done_ff) ? conv_ff + 4'h1 : 4'h0;
      end
   end
   // Wide pulses so the synchroniser sees every edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_ff <= 4'h0;
      end else if (ext_step) begin
         ext_ff <= 4'(EXT_HIGH);
      end else if (ext_ff != 4'h0) begin
         ext_ff <= ext_ff - 4'h1;
      end
   end
endmodule // ccpc_partner
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        sleep_mode;
   logic        ext_step;
   logic        t1_ext_clk;
   logic        adc_done;
   logic        adc_go;
   logic [1:0]  special_event;
   logic [5:0]  pin;
   logic [31:0] exp_q[$];
   logic [31:0] mon_e;
   logic [15:0] lf;
   logic [15:0] v;
   logic [15:0] tc;
   logic        go_seen;
   int          errors;
   int          checks_done;
   logic [3:0]  md [8] = '{4'h8, 4'h2, 4'hb, 4'ha, 4'h9, 4'h8, 4'h0, 4'h2};
   logic [7:0]  ra [8] = '{8'h00, 8'h04, 8'h18, 8'h2c, 8'h30, 8'h34, 8'h38, 8'h40};
   logic [7:0]  ep = 8'ha5;
   logic [7:0]  eo = 8'hb3;
   logic [7:0]  es = 8'hbf;
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   ccpc_top u_ccpc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
      .t1_ext_clk(t1_ext_clk), .sleep_mode(sleep_mode), .adc_done(adc_done), .adc_go(adc_go),
      .special_event(special_event), .cmp1_pin(pin[0]), .cmp1_pin_oe(pin[1]), .port_c_pin1(pin[2]),
      .port_c_pin1_oe(pin[3]), .port_b_pin3(pin[4]), .port_b_pin3_oe(pin[5]));
   ccpc_partner u_ccpc_partner (.pclk(pclk), .presetn(presetn), .adc_go(adc_go), .adc_done(adc_done),
      .ext_step(ext_step), .t1_ext_clk(t1_ext_clk));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, {24'h0, d[7:0]});
      wr(a + 8'h04, {24'h0, d[15:8]});
   endtask
   task automatic chk(input string n, input logic s, input logic e);
      checks_done++;
      if (s !== e) begin
         errors++;
         $display("mismatch %s exp %b got %b", n, e, s);
      end
   endtask
   // Timer stopped while loading so no stray match on half-written values
   task automatic arm(input logic [7:0] ctl, input logic [3:0] m);
      wr(ccpc_pkg::OFS_TMR_CTL, 32'h0);
      wr(ctl, {28'h0, m});
      wr16(ccpc_pkg::OFS_TMR_LO, v - 16'h2);
      wr(ccpc_pkg::OFS_TMR_CTL, 32'h1);
      repeat (20) @(posedge pclk);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      if (adc_go === 1'b1) go_seen = 1'b1;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         mon_e = exp_q.pop_front();
         checks_done++;
         if (prdata !== mon_e) begin
            errors++;
            $display("mismatch reg %h exp %h got %h", paddr, mon_e, prdata);
         end
      end
   end
   initial begin
      repeat (6000) @(posedge pclk);
      errors++;
      test_done;
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, sleep_mode, ext_step, go_seen} = '0;
      errors = 0;
      checks_done = 0;
      lf = lfsr(lfsr(16'h5112));
      v = {lf[15:8] | 8'h01, 4'h8, lf[3:0]};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      wr(8'h40, 32'hff);
      wr(ccpc_pkg::OFS_IRQ_ST, 32'h7);
      for (int i = 0; i < 8; i++) rd(ra[i], (i == 6) ? 32'h7 : 32'h0);
      $display("test reset values done");
      wr(ccpc_pkg::OFS_PINDIR, 32'h0);
      wr(ccpc_pkg::OFS_IRQ_EN, 32'h1);
      wr16(ccpc_pkg::OFS_VAL1_LO, v);
      for (int i = 0; i < 8; i++) begin
         arm(ccpc_pkg::OFS_CTRL1, md[i]);
         chk("cmp1_oe", pin[1], eo[i]);
         if (eo[i]) chk("cmp1_pin", pin[0], ep[i]);
         chk("irq", irq, es[i]);
         rd(ccpc_pkg::OFS_IRQ_ST, {31'h0, es[i]});
         wr(ccpc_pkg::OFS_IRQ_CLR, 32'h1);
      end
      $display("test compare modes done");
      wr16(ccpc_pkg::OFS_VAL2_LO, v);
      for (int a = 0; a < 2; a++) begin
         wr(ccpc_pkg::OFS_ALTPIN, a);
         arm(ccpc_pkg::OFS_CTRL2, ccpc_pkg::MODE_SET);
         chk("pc_oe", pin[3], !a[0]);
         chk("pb_oe", pin[5], a[0]);
         chk("alt_pin", pin[2 + 2 * a], 1'b1);
      end
      wr(ccpc_pkg::OFS_IRQ_CLR, 32'h7);
      $display("test alternate pin done");
      wr(ccpc_pkg::OFS_CTRL1, 32'h0);
      wr(ccpc_pkg::OFS_CTRL2, {28'h0, ccpc_pkg::MODE_TRIG});
      wr(ccpc_pkg::OFS_ADC, 32'h1);
      for (int c = 0; c < 3; c++) begin
         wr(ccpc_pkg::OFS_TMR_CTL, 32'h0);
         sleep_mode <= (c == 0);
         wr16(ccpc_pkg::OFS_TMR_LO, v);
         wr(ccpc_pkg::OFS_TMR_CTL, 32'h3);
         repeat (10) @(posedge pclk);
         rd(ccpc_pkg::OFS_IRQ_ST, (c == 0) ? 32'h0 : 32'h2);
         chk("irq_masked", irq, 1'b0);
         wr(ccpc_pkg::OFS_IRQ_CLR, 32'h7);
         repeat (10) @(posedge pclk);
         rd(ccpc_pkg::OFS_IRQ_ST, 32'h0);
         if (c == 1) wr(ccpc_pkg::OFS_VAL2_HI, {24'h0, v[15:8] ^ 8'h80});
         ext_step <= 1'b1;
         @(posedge pclk);
         ext_step <= 1'b0;
         repeat (20) @(posedge pclk);
         tc = (c == 0) ? v : (c == 1) ? v + 16'h1 : 16'h0;
         rd(ccpc_pkg::OFS_TMR_LO, {24'h0, tc[7:0]});
         rd(ccpc_pkg::OFS_TMR_HI, {24'h0, tc[15:8]});
         rd(ccpc_pkg::OFS_IRQ_ST, 32'h0);
         wr(ccpc_pkg::OFS_VAL2_HI, {24'h0, v[15:8]});
         sleep_mode <= 1'b0;
      end
      chk("go_seen", go_seen, 1'b1);
      rd(ccpc_pkg::OFS_ADC, 32'h1);
      wr(ccpc_pkg::OFS_IRQ_EN, 32'h0);
      repeat (4) @(posedge pclk);
      $display("test special event done");
      test_done;
   end
endmodule // testbench
`default_nettype wire
